//--- src/phg_pkg.sv
// Shared constants and carrier types for the port H general-purpose block
package phg_pkg;
	// Port width and the width of each peripheral half
	localparam int PHG_PINS = 8;
	localparam int PHG_HALF = 4;
	// Register offsets
	localparam logic [7:0] PHG_OFS_PORTP_POL = 8'h1d;
	localparam logic [7:0] PHG_OFS_PORTP_IEN = 8'h1e;
	localparam logic [7:0] PHG_OFS_PORTP_FLG = 8'h1f;
	localparam logic [7:0] PHG_OFS_DATA = 8'h20;
	localparam logic [7:0] PHG_OFS_PIN_IN = 8'h21;
	localparam logic [7:0] PHG_OFS_DIR = 8'h22;
	localparam logic [7:0] PHG_OFS_RDRV = 8'h23;
	localparam logic [7:0] PHG_OFS_PULL = 8'h24;
	localparam logic [7:0] PHG_OFS_POL = 8'h25;
	localparam logic [7:0] PHG_OFS_IEN = 8'h26;
	localparam logic [7:0] PHG_OFS_FLG = 8'h27;
	// Values after reset
	localparam logic [7:0] PHG_RST_REG = 8'h00;
	localparam logic [7:0] PHG_RST_RDATA = 8'h00;
	// Register bus request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} phg_bus_req_t;
	// Serial peripheral takeover: enables and per-pin drive
	typedef struct packed {
		logic en_first;
		logic en_second;
		logic [7:0] dout;
		logic [7:0] doe;
	} phg_sp_ctrl_t;
	// Pad controls toward the port H pins
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pull_up;
		logic [7:0] pull_dn;
		logic [7:0] reduced;
	} phg_pad_ctrl_t;
endpackage

//--- src/phg_edge_sync.sv
// Two-stage pin synchroniser with polarity-selected edge detection
module phg_edge_sync import phg_pkg::*; #(
	parameter int W = PHG_PINS
) (
	// Clock, reset, enable
	input wire logic clock,
	input wire logic nrst,
	input wire logic ce,
	// Asynchronous pin levels and edge polarity
	input wire logic [W-1:0] pin_async,
	input wire logic [W-1:0] polarity,
	// Synchronised level and one-cycle edge hits
	output logic [W-1:0] level,
	output logic [W-1:0] edge_hit
);
	logic [W-1:0] meta;
	logic [W-1:0] prev;

	if (W < 1) begin : g_chk
		$error("phg_edge_sync: width must be at least one");
	end

	// First stage feeds only the second stage
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			meta <= '0;
			level <= '0;
		end else if (ce) begin
			meta <= pin_async;
			level <= meta;
		end
	end

	// Previous synchronised level; reset low so a high pin looks like a rise only
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			prev <= '0;
		end else if (ce) begin
			prev <= level;
		end
	end

	// Set polarity picks rising, cleared picks falling
	assign edge_hit = (polarity & level & ~prev) | (~polarity & ~level & prev);
endmodule

//--- src/phg_flag_bank.sv
// Sticky edge flags with write-one-to-clear and a masked request
module phg_flag_bank import phg_pkg::*; #(
	parameter int W = PHG_PINS
) (
	// Clock, reset, enable
	input wire logic clock,
	input wire logic nrst,
	input wire logic ce,
	// Edge hits, clear mask, enables
	input wire logic [W-1:0] edge_hit,
	input wire logic [W-1:0] clear,
	input wire logic [W-1:0] enable,
	// Flags and request
	output logic [W-1:0] flags,
	output logic irq
);
	if (W < 1) begin : g_chk
		$error("phg_flag_bank: width must be at least one");
	end

	// A hit in the clearing cycle survives: set beats clear
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			flags <= '0;
		end else if (ce) begin
			flags <= (flags & ~clear) | edge_hit;
		end
	end

	// One request line for the whole port
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |(flags & enable);
		end
	end
endmodule

//--- src/phg_top.sv
// Port H general-purpose port with edge flags, plus port P flag registers
//
// Our own choice: the strobed register port.
module phg_top import phg_pkg::*; #(
	parameter int PINS = PHG_PINS
) (
	// Clock, reset, clock enable
	input wire logic clock,
	input wire logic nrst,
	input wire logic ce,
	// Register bus
	input wire phg_bus_req_t bus_req,
	output logic [7:0] rdata,
	// Port H pins
	input wire logic [7:0] porth_pin_in,
	output phg_pad_ctrl_t porth_pad,
	// Port P pin levels
	input wire logic [7:0] portp_pin_in,
	// Serial peripherals
	input wire phg_sp_ctrl_t sp_ctrl,
	output logic [7:0] porth_level,
	// Interrupt requests
	output logic irq_porth,
	output logic irq_portp
);
	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [7:0] porth_data;
	logic [7:0] porth_direction;
	logic [7:0] porth_reduced_drive;
	logic [7:0] porth_pull_enable;
	logic [7:0] porth_polarity_select;
	logic [7:0] porth_pin_irq_enable;
	logic [7:0] porth_pin_irq_flags;
	logic [7:0] portp_polarity_select;
	logic [7:0] portp_pin_irq_enable;
	logic [7:0] portp_pin_irq_flags;
	logic [7:0] portp_level;
	logic [7:0] edge_h;
	logic [7:0] edge_p;
	logic [7:0] clr_h;
	logic [7:0] clr_p;
	logic [7:0] owned;
	logic [7:0] gp_input;
	logic [7:0] next_rdata;
	phg_pad_ctrl_t next_pad;

	// The register file is eight bits wide
	if (PINS != PHG_PINS) begin : g_chk
		$error("phg_top: only eight pins are supported");
	end

	////////////////////////////////////////////////////////////////////////////
	// Write decode

	// Write strobe matched against one offset; callers gate it with the clock enable
	function automatic logic wr_hit(input phg_bus_req_t r, input logic [7:0] ofs);
		wr_hit = r.wr && (r.addr == ofs);
	endfunction

	// General-purpose control registers; the pin-input offset has no storage
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			porth_data <= PHG_RST_REG;
			porth_direction <= PHG_RST_REG;
			porth_reduced_drive <= PHG_RST_REG;
			porth_pull_enable <= PHG_RST_REG;
		end else if (ce) begin
			if (wr_hit(bus_req, PHG_OFS_DATA)) begin
				porth_data <= bus_req.wdata;
			end
			if (wr_hit(bus_req, PHG_OFS_DIR)) begin
				porth_direction <= bus_req.wdata;
			end
			if (wr_hit(bus_req, PHG_OFS_RDRV)) begin
				porth_reduced_drive <= bus_req.wdata;
			end
			if (wr_hit(bus_req, PHG_OFS_PULL)) begin
				porth_pull_enable <= bus_req.wdata;
			end
		end
	end

	// Polarity and enable registers for both ports
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			porth_polarity_select <= PHG_RST_REG;
			porth_pin_irq_enable <= PHG_RST_REG;
			portp_polarity_select <= PHG_RST_REG;
			portp_pin_irq_enable <= PHG_RST_REG;
		end else if (ce) begin
			if (wr_hit(bus_req, PHG_OFS_POL)) begin
				porth_polarity_select <= bus_req.wdata;
			end
			if (wr_hit(bus_req, PHG_OFS_IEN)) begin
				porth_pin_irq_enable <= bus_req.wdata;
			end
			if (wr_hit(bus_req, PHG_OFS_PORTP_POL)) begin
				portp_polarity_select <= bus_req.wdata;
			end
			if (wr_hit(bus_req, PHG_OFS_PORTP_IEN)) begin
				portp_pin_irq_enable <= bus_req.wdata;
			end
		end
	end

	// Write-one-to-clear masks toward the flag banks
	assign clr_h = wr_hit(bus_req, PHG_OFS_FLG) ? bus_req.wdata : 8'h00;
	assign clr_p = wr_hit(bus_req, PHG_OFS_PORTP_FLG) ? bus_req.wdata : 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and flags

	// Port H pins cross into the bus clock before any use
	phg_edge_sync #(.W(PHG_PINS)) u_sync_h (
		.clock(clock),
		.nrst(nrst),
		.ce(ce),
		.pin_async(porth_pin_in),
		.polarity(porth_polarity_select),
		.level(porth_level),
		.edge_hit(edge_h)
	);

	// Port P pins, polarity from their own register
	phg_edge_sync #(.W(PHG_PINS)) u_sync_p (
		.clock(clock),
		.nrst(nrst),
		.ce(ce),
		.pin_async(portp_pin_in),
		.polarity(portp_polarity_select),
		.level(portp_level),
		.edge_hit(edge_p)
	);

	// Port H flags and request
	phg_flag_bank #(.W(PHG_PINS)) u_flags_h (
		.clock(clock),
		.nrst(nrst),
		.ce(ce),
		.edge_hit(edge_h),
		.clear(clr_h),
		.enable(porth_pin_irq_enable),
		.flags(porth_pin_irq_flags),
		.irq(irq_porth)
	);

	// Port P flags and request
	phg_flag_bank #(.W(PHG_PINS)) u_flags_p (
		.clock(clock),
		.nrst(nrst),
		.ce(ce),
		.edge_hit(edge_p),
		.clear(clr_p),
		.enable(portp_pin_irq_enable),
		.flags(portp_pin_irq_flags),
		.irq(irq_portp)
	);

	////////////////////////////////////////////////////////////////////////////
	// Pad control

	// Each peripheral takes its half of the port while enabled
	assign owned = {{PHG_HALF{sp_ctrl.en_second}}, {PHG_HALF{sp_ctrl.en_first}}};
	assign gp_input = ~owned & ~porth_direction;

	// Pulls only on general-purpose inputs; drive strength only where driven
	always_comb begin
		next_pad.out = (owned & sp_ctrl.dout) | (~owned & porth_data);
		next_pad.oe = (owned & sp_ctrl.doe) | (~owned & porth_direction);
		next_pad.pull_up = gp_input & porth_pull_enable & ~porth_polarity_select;
		next_pad.pull_dn = gp_input & porth_pull_enable & porth_polarity_select;
		next_pad.reduced = next_pad.oe & porth_reduced_drive;
	end

	// Registered pads: one cycle after a write the pins follow
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			porth_pad <= '0;
		end else if (ce) begin
			porth_pad <= next_pad;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read path

	// Unmapped offsets read as zero
	always_comb begin
		next_rdata = PHG_RST_RDATA;
		case (bus_req.addr)
			PHG_OFS_PORTP_POL: next_rdata = portp_polarity_select;
			PHG_OFS_PORTP_IEN: next_rdata = portp_pin_irq_enable;
			PHG_OFS_PORTP_FLG: next_rdata = portp_pin_irq_flags;
			PHG_OFS_DATA: next_rdata = (porth_direction & porth_data) | (~porth_direction & porth_level);
			PHG_OFS_PIN_IN: next_rdata = porth_level;
			PHG_OFS_DIR: next_rdata = porth_direction;
			PHG_OFS_RDRV: next_rdata = porth_reduced_drive;
			PHG_OFS_PULL: next_rdata = porth_pull_enable;
			PHG_OFS_POL: next_rdata = porth_polarity_select;
			PHG_OFS_IEN: next_rdata = porth_pin_irq_enable;
			PHG_OFS_FLG: next_rdata = porth_pin_irq_flags;
			default: next_rdata = PHG_RST_RDATA;
		endcase
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rdata <= PHG_RST_RDATA;
		end else if (ce) begin
			rdata <= bus_req.rd ? next_rdata : PHG_RST_RDATA;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	// Every edge hit is caught in its flag
	property p_flag_set;
		@(posedge clock) disable iff (!nrst)
		(ce && edge_h != 8'h00) |=> ((porth_pin_irq_flags & $past(edge_h)) == $past(edge_h));
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("edge hit did not set its flag");

	// Ones clear, zeros keep, when no edge competes
	property p_w1c;
		@(posedge clock) disable iff (!nrst)
		(ce && bus_req.wr && bus_req.addr == PHG_OFS_FLG && edge_h == 8'h00)
			|=> porth_pin_irq_flags == ($past(porth_pin_irq_flags) & ~$past(bus_req.wdata));
	endproperty
	a_w1c: assert property (p_w1c) else $error("flag write-one-to-clear wrong");

	// Enabled flag raises the request a cycle later
	property p_irq_req;
		@(posedge clock) disable iff (!nrst)
		(ce && (porth_pin_irq_flags & porth_pin_irq_enable) != 8'h00) |=> irq_porth;
	endproperty
	a_irq_req: assert property (p_irq_req) else $error("enabled flag gave no request");

	// Masked flags give no request
	property p_irq_mask;
		@(posedge clock) disable iff (!nrst)
		(ce && (porth_pin_irq_flags & porth_pin_irq_enable) == 8'h00) |=> !irq_porth;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("masked flag raised request");

	// Edge direction agrees with polarity and the level now seen
	property p_edge_dir;
		@(posedge clock) disable iff (!nrst)
		ce |-> ((edge_h & (porth_polarity_select ^ porth_level)) == 8'h00);
	endproperty
	a_edge_dir: assert property (p_edge_dir) else $error("edge against polarity");

	// Pull direction follows polarity for pulled general-purpose inputs
	property p_pull_sel;
		@(posedge clock) disable iff (!nrst)
		ce |=> porth_pad.pull_up == $past(gp_input & porth_pull_enable & ~porth_polarity_select)
			&& porth_pad.pull_dn == $past(gp_input & porth_pull_enable & porth_polarity_select);
	endproperty
	a_pull_sel: assert property (p_pull_sel) else $error("pull selection wrong");

	// Never a pull on a driven pin, never both pulls
	property p_pull_out;
		@(posedge clock) disable iff (!nrst)
		((porth_pad.pull_up | porth_pad.pull_dn) & porth_pad.oe) == 8'h00
			&& (porth_pad.pull_up & porth_pad.pull_dn) == 8'h00;
	endproperty
	a_pull_out: assert property (p_pull_out) else $error("pull on output pin");

	// Direction bits drive enables of unowned pins
	property p_dir;
		@(posedge clock) disable iff (!nrst)
		ce |=> ((porth_pad.oe ^ $past(porth_direction)) & ~$past(owned)) == 8'h00;
	endproperty
	a_dir: assert property (p_dir) else $error("direction not applied");

	// Data read mixes stored value and pin level
	property p_data_read;
		@(posedge clock) disable iff (!nrst)
		(ce && bus_req.rd && bus_req.addr == PHG_OFS_DATA)
			|=> rdata == (($past(porth_direction) & $past(porth_data)) | (~$past(porth_direction) & $past(porth_level)));
	endproperty
	a_data_read: assert property (p_data_read) else $error("data read wrong");

	// Pin-input read shows the synchronised levels
	property p_pin_read;
		@(posedge clock) disable iff (!nrst)
		(ce && bus_req.rd && bus_req.addr == PHG_OFS_PIN_IN) |=> rdata == $past(porth_level);
	endproperty
	a_pin_read: assert property (p_pin_read) else $error("pin-input read wrong");

	// A write to the pin-input offset leaves control state alone
	property p_pin_wr;
		@(posedge clock) disable iff (!nrst)
		(ce && bus_req.wr && bus_req.addr == PHG_OFS_PIN_IN)
			|=> $stable(porth_data) && $stable(porth_direction) && $stable(porth_pull_enable)
			&& $stable(porth_reduced_drive) && $stable(porth_polarity_select);
	endproperty
	a_pin_wr: assert property (p_pin_wr) else $error("pin-input write changed state");

	// Reduced drive only on driven pins
	property p_reduced;
		@(posedge clock) disable iff (!nrst)
		(porth_pad.reduced & ~porth_pad.oe) == 8'h00;
	endproperty
	a_reduced: assert property (p_reduced) else $error("reduced drive on input");

	// Upper half follows the second peripheral while it owns it
	property p_owner;
		@(posedge clock) disable iff (!nrst)
		(ce && sp_ctrl.en_second) |=> porth_pad.oe[7:4] == $past(sp_ctrl.doe[7:4])
			&& porth_pad.out[7:4] == $past(sp_ctrl.dout[7:4]);
	endproperty
	a_owner: assert property (p_owner) else $error("upper pins not handed over");

	// Port P request tracks its enabled flags
	property p_irq_p;
		@(posedge clock) disable iff (!nrst)
		ce |=> irq_portp == $past(|(portp_pin_irq_flags & portp_pin_irq_enable));
	endproperty
	a_irq_p: assert property (p_irq_p) else $error("port P request wrong");

	// Port P edges follow their own polarity
	property p_edge_p;
		@(posedge clock) disable iff (!nrst)
		ce |-> ((edge_p & (portp_polarity_select ^ portp_level)) == 8'h00);
	endproperty
	a_edge_p: assert property (p_edge_p) else $error("port P edge against polarity");

	// No bit hits twice in a row
	property p_once;
		@(posedge clock) disable iff (!nrst)
		(ce && edge_h != 8'h00) |=> (!ce || (edge_h & $past(edge_h)) == 8'h00);
	endproperty
	a_once: assert property (p_once) else $error("edge counted twice");
endmodule

//--- test/phg_pin_model.sv
// Pin-side model: resolves port H pin levels from pads, pulls and outside drivers
module phg_pin_model import phg_pkg::*; (
	// Clock
	input wire logic clock,
	// Pad controls from the port
	input wire phg_pad_ctrl_t pad,
	// Outside drivers
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_en,
	// Resolved pin levels
	output logic [7:0] pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] last = 8'h00;

	////////////////////////////////////////////////////////////////
	// Port drive wins over outside drivers; a floating pin shows the inverse of its
	// last level, so a stale value can never pass for a real one
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pad.oe[i]) pin[i] = pad.out[i];
			else if (ext_en[i]) pin[i] = ext_val[i];
			else if (pad.pull_up[i]) pin[i] = 1'b1;
			else if (pad.pull_dn[i]) pin[i] = 1'b0;
			else pin[i] = ~last[i];
		end
	end

	// Remember the level of the previous cycle
	always @(posedge clock) begin
		last <= pin;
	end
endmodule

//--- test/tb_port_h_gpio_pin_interrupt.sv
// Self-checking bench for the port H block with its pin-side model
module tb_port_h_gpio_pin_interrupt import phg_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1;
	phg_bus_req_t req = '0;
	logic [7:0] rdata;
	logic [7:0] pins;
	phg_pad_ctrl_t pad;
	logic [7:0] pp = 8'h00;
	phg_sp_ctrl_t sp = '0;
	logic [7:0] level;
	logic irq_h;
	logic irq_p;
	logic [7:0] ext_val = 8'h00;
	logic [7:0] ext_en = 8'hff;
	int fails = 0;
	int num_checks = 0;

	////////////////////////////////////////////////////////////////
	// Design, pin model and clock
	phg_top #(.PINS(8)) uut (.clock(clock), .nrst(nrst), .ce(ce), .bus_req(req), .rdata(rdata),
		.porth_pin_in(pins), .porth_pad(pad), .portp_pin_in(pp), .sp_ctrl(sp), .porth_level(level),
		.irq_porth(irq_h), .irq_portp(irq_p));
	phg_pin_model pm (.clock(clock), .pad(pad), .ext_val(ext_val), .ext_en(ext_en), .pin(pins));
	always #2.5 clock = ~clock;

	////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic close_out();
		$display("checks=%0d mismatches=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge clock);
		req <= '0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clock);
		req <= '0;
		#1 chk(rdata, exp);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		for (int a = 8'h1d; a <= 8'h27; a++) begin
			rd(8'(a), 8'h00);
		end
		wr(8'h30, 8'hff);
		rd(8'h30, 8'h00);
		@(posedge clock) ce <= 1'b0;
		wr(PHG_OFS_DIR, 8'hff);
		ce <= 1'b1;
		rd(PHG_OFS_DIR, 8'h00);
		$display("done reset and map");
	endtask
	task automatic t_regs();
		ext_en <= 8'hf0;
		ext_val <= 8'h50;
		wr(PHG_OFS_DIR, 8'h0f);
		wr(PHG_OFS_DATA, 8'ha5);
		wr(PHG_OFS_RDRV, 8'hff);
		settle(2);
		chk(pad.oe, 8'h0f);
		chk(pad.out & pad.oe, 8'h05);
		chk(pad.reduced, 8'h0f);
		rd(PHG_OFS_DATA, 8'h55);
		rd(PHG_OFS_PIN_IN, 8'h55);
		wr(PHG_OFS_PIN_IN, 8'hff);
		rd(PHG_OFS_PIN_IN, 8'h55);
		rd(PHG_OFS_DATA, 8'h55);
		wr(PHG_OFS_PULL, 8'hff);
		wr(PHG_OFS_POL, 8'hcc);
		ext_en <= 8'h00;
		settle(2);
		chk(pad.pull_up, 8'h30);
		chk(pad.pull_dn, 8'hc0);
		rd(PHG_OFS_PIN_IN, 8'h35);
		ext_val <= 8'h00;
		ext_en <= 8'hff;
		wr(PHG_OFS_PULL, 8'h00);
		wr(PHG_OFS_DIR, 8'h00);
		wr(PHG_OFS_RDRV, 8'h00);
		$display("done registers and pads");
	endtask
	task automatic t_edges();
		wr(PHG_OFS_POL, 8'h0f);
		wr(PHG_OFS_IEN, 8'hff);
		wr(PHG_OFS_FLG, 8'hff);
		settle(4);
		rd(PHG_OFS_FLG, 8'h00);
		chk(irq_h, 1'b0);
		ext_val <= 8'hff;
		settle(6);
		rd(PHG_OFS_FLG, 8'h0f);
		chk(irq_h, 1'b1);
		chk(level, 8'hff);
		settle(10);
		rd(PHG_OFS_FLG, 8'h0f);
		ext_val <= 8'h00;
		settle(6);
		rd(PHG_OFS_FLG, 8'hff);
		wr(PHG_OFS_FLG, 8'h05);
		rd(PHG_OFS_FLG, 8'hfa);
		wr(PHG_OFS_IEN, 8'h00);
		settle(2);
		chk(irq_h, 1'b0);
		wr(PHG_OFS_IEN, 8'h02);
		settle(2);
		chk(irq_h, 1'b1);
		wr(PHG_OFS_FLG, 8'hff);
		settle(2);
		chk(irq_h, 1'b0);
		// Rising edge lands in the very cycle its clear is taken: the set must win
		@(posedge clock) ext_val <= 8'h01;
		@(posedge clock);
		wr(PHG_OFS_FLG, 8'h01);
		rd(PHG_OFS_FLG, 8'h01);
		$display("done port H edges");
	endtask
	task automatic t_portp();
		wr(PHG_OFS_PORTP_POL, 8'h01);
		wr(PHG_OFS_PORTP_IEN, 8'h01);
		pp <= 8'hff;
		settle(6);
		rd(PHG_OFS_PORTP_FLG, 8'h01);
		chk(irq_p, 1'b1);
		@(posedge clock) pp <= 8'h00;
		settle(6);
		rd(PHG_OFS_PORTP_FLG, 8'hff);
		wr(PHG_OFS_PORTP_FLG, 8'hfe);
		rd(PHG_OFS_PORTP_FLG, 8'h01);
		wr(PHG_OFS_PORTP_IEN, 8'h00);
		settle(2);
		chk(irq_p, 1'b0);
		$display("done port P flags");
	endtask
	task automatic t_periph();
		wr(PHG_OFS_DATA, 8'hff);
		wr(PHG_OFS_POL, 8'h00);
		wr(PHG_OFS_PULL, 8'hff);
		@(posedge clock);
		ext_en <= 8'h00;
		sp <= '{1'b0, 1'b1, 8'ha0, 8'hf0};
		settle(2);
		chk(pad.oe, 8'hf0);
		chk(pad.out & pad.oe, 8'ha0);
		chk(pad.pull_up, 8'h0f);
		@(posedge clock) sp <= '{1'b1, 1'b1, 8'ha5, 8'hff};
		settle(2);
		chk(pad.oe, 8'hff);
		chk(pad.out, 8'ha5);
		chk(pad.pull_up, 8'h00);
		rd(PHG_OFS_PIN_IN, 8'ha5);
		@(posedge clock) sp <= '{1'b1, 1'b0, 8'h0a, 8'h0f};
		settle(2);
		chk(pad.oe, 8'h0f);
		chk(pad.pull_up, 8'hf0);
		@(posedge clock) sp <= '0;
		settle(2);
		chk(pad.oe, 8'h00);
		chk(pad.pull_up, 8'hff);
		$display("done serial takeover");
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence: reset held for 16 cycles, checked in the middle
	initial begin
		repeat (8) @(posedge clock);
		#1 chk(pad.oe | pad.pull_up | pad.pull_dn, 8'h00);
		chk({6'h00, irq_h, irq_p}, 8'h00);
		repeat (8) @(posedge clock);
		nrst <= 1'b1;
		t_reset();
		t_regs();
		t_edges();
		t_portp();
		t_periph();
		close_out();
	end

	// Watchdog well beyond the expected run of a few hundred cycles
	initial begin
		#20000;
		fails++;
		close_out();
	end
endmodule
